// File: ssq_pin_model.sv
// Board reset circuit on the bidirectional reset pin: a pull-up and a switch.
// Assumes the sequencer drives its pin value only while its enable is low.
`timescale 1ns/1ps
module ssq_pin_model (
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe_n,
  input  wire logic i_hold_low,
  output logic      o_pin
);
  // Any low driver wins; otherwise the pull-up brings the wire high at once.
  assign o_pin = ((!i_pin_oe_n && !i_pin_out) || i_hold_low) ? 1'b0 : 1'b1;
endmodule

// File: ssq_pkg.sv
// Constants, state codes and bus carrier for the stop/wake and reset sequencer.
// Assumes a single 200 MHz core clock and a plain register port.
package ssq_pkg;
  // Register byte offsets.
  localparam logic [3:0] ADDR_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_STAT  = 4'h4;
  localparam logic [3:0] ADDR_MASK  = 4'h8;
  localparam logic [3:0] ADDR_STATE = 4'hC;
  // Control bit positions and reset value.
  localparam int CB_CLE = 0;
  localparam int CB_SFE = 1;
  localparam int CB_SIE = 2;
  localparam int CB_LSS = 3;
  localparam int CB_LCS = 4;
  localparam logic [4:0] CTRL_RST = 5'h03;
  // Status and mask bit positions.
  localparam int SB_SCF  = 0;
  localparam int SB_WAKE = 1;
  localparam int SB_CHK  = 2;
  // Cycle and window counts.
  localparam logic [7:0]  PIN_LOW_CYC = 8'h80;
  localparam logic [7:0]  SYNC_EXTRA  = 8'h03;
  localparam logic [7:0]  SAMPLE_CYC  = 8'h40;
  localparam logic [12:0] WIN_CYC     = 13'h1000;
  localparam logic [5:0]  MAX_WIN     = 6'h32;
  // Synchroniser reset: pin idles high, oscillator fail idles low.
  localparam logic [1:0]  SYNC_RST    = 2'h1;
  typedef enum logic [1:0] {
    VEC_POR  = 2'h0,
    VEC_CLK  = 2'h1,
    VEC_WDOG = 2'h2
  } ssq_vec_t;
  typedef enum logic [3:0] {
    R_IDLE  = 4'h1,
    R_DRIVE = 4'h2,
    R_WAIT  = 4'h4,
    R_HOLD  = 4'h8
  } ssq_rst_t;
  typedef enum logic [3:0] {
    P_RUN    = 4'h1,
    P_PSEUDO = 4'h2,
    P_FULL   = 4'h4,
    P_FCHK   = 4'h8
  } ssq_pwr_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } ssq_bus_t;
endpackage

// File: ssq_seq.sv
// Stop/wake and reset sequencer: reset pin driver, vector choice, clock check.
// Assumes pin and oscillator-fail inputs are asynchronous; others are on-clock.
// Contract
// - Clock loss in light sleep, detect on, fallback off: clock-loss reset at once.
// - Fallback on, irq off: stay asleep, enable regulator and loop, self-clock, flag.
// - Oscillator clean for a full window: leave self-clock, power down, stay asleep.
// - After recovery, wakeup irq exits on crystal clock; external reset starts sequence.
// - No recovery: keep checking; wake exits still in self-clock, checking continues.
// - Fallback and irq on: set flag, wake, exit in self-clock, keep checking.
// - Deep sleep ends only on external interrupt or external reset.
// - External reset in deep sleep: defaults, up to 50 windows, then reset sequence (here defaults load only as the reset sequence starts).
// - Interrupt wake from deep sleep: 50 windows; all fail gives self-clock or reset.
// - Leaving sleep clears loop clock select; software sets it again.
// - Clock loss detection is off in deep sleep.
// - Pin low, power-on, low voltage, watchdog, clock loss without fallback start reset.
// - Reset entry is asynchronous; leaving reset needs the clock (here only i_reset enters asynchronously; other sources enter on a clock edge).
// - Pin driven low 128 cycles plus synchronisation latency, then released.
// - Wait 64 cycles after release, then sample the pin.
// - Pin low: power-on vector after rise; else clock, then watchdog, then power-on.
// - Internal reset holds for the whole sequence, released synchronously.
// - Internal reset holds while the pin is held low beyond the sequence.
// - Loss with irq off sets the flag but does not wake light sleep.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module ssq_seq (
  input  wire logic              i_core_clk,
  input  wire logic              i_reset,
  input  wire ssq_pkg::ssq_bus_t i_bus,
  output logic [31:0]            o_rdata,
  input  wire logic              i_rst_pin,
  output logic                   o_rst_pin_out,
  output logic                   o_rst_pin_oe_n,
  input  wire logic              i_osc_fail,
  input  wire logic              i_wdog_timeout,
  input  wire logic              i_low_volt,
  input  wire logic              i_stop_req,
  input  wire logic              i_wakeup_irq,
  output logic                   o_int_reset,
  output ssq_pkg::ssq_vec_t      o_vector,
  output logic                   o_vector_valid,
  output logic                   o_selfclock_mode,
  output logic                   o_regulator_en,
  output logic                   o_loop_osc_en,
  output logic                   o_loop_clock_sel,
  output logic                   o_stopped,
  output logic                   o_irq
);
  import ssq_pkg::*;

  localparam int A_DRV  = 131;
  localparam int A_WAIT = 63;

  logic [1:0]  s1_q, s2_q, s3_q, f_q;
  logic [4:0]  ctrl_q;
  logic [2:0]  stat_q, mask_q, stat_set;
  ssq_rst_t    rs_q, rs_d;
  ssq_pwr_t    pwr_q, pwr_d;
  logic [7:0]  seq_cnt_q;
  logic [12:0] win_cnt_q;
  logic [5:0]  nwin_q;
  logic        bad_q, scm_q, scm_d, por_q, cm_pend_q, wd_pend_q, ext_pend_q;
  logic        pin_low, osc_bad, loss_det, scm_set, qc_on, win_end, qc_ok;
  logic        fchk_fail, cm_rst_ev, rst_ev, seq_done, in_stop_d;
  ssq_vec_t    vec_d;

  // Three-stage synchroniser; a change counts once stages two and three agree.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      f_q  <= SYNC_RST;
    end else begin
      s1_q <= {i_osc_fail, i_rst_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int k = 0; k < 2; k++) begin
        if (s2_q[k] == s3_q[k]) begin
          f_q[k] <= s3_q[k];
        end
      end
    end
  end

  assign pin_low = ~f_q[0];
  assign osc_bad = f_q[1];

  // Clock monitor and clock quality checker.
  assign loss_det  = ctrl_q[CB_CLE] & osc_bad & (pwr_q != P_FULL) & (pwr_q != P_FCHK);
  assign scm_set   = loss_det & ctrl_q[CB_SFE] & ~scm_q;
  assign qc_on     = scm_q | (pwr_q == P_FCHK);
  assign win_end   = qc_on & (win_cnt_q == WIN_CYC - 13'h0001);
  assign qc_ok     = win_end & ~bad_q & ~osc_bad;
  assign fchk_fail = (pwr_q == P_FCHK) & win_end & ~qc_ok & (nwin_q == MAX_WIN - 6'h01);
  assign cm_rst_ev = (loss_det & ~ctrl_q[CB_SFE]) | (fchk_fail & ~ctrl_q[CB_SFE]);
  assign seq_done  = ((rs_q == R_WAIT) & (seq_cnt_q == SAMPLE_CYC - 8'h01) & ~pin_low)
                   | ((rs_q == R_HOLD) & ~pin_low);

  // Reset sources; a pin low in deep sleep waits for the clock check first.
  assign rst_ev = por_q | i_low_volt | i_wdog_timeout | cm_rst_ev
                | (ext_pend_q & (pwr_q == P_FCHK) & (qc_ok | fchk_fail))
                | (pin_low & (rs_q == R_IDLE) & (pwr_q != P_FULL) & (pwr_q != P_FCHK));

  // Window counter: in self-clock a failure restarts the window, in deep-sleep check it sticks.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      win_cnt_q <= '0;
      bad_q     <= 1'b0;
      nwin_q    <= '0;
    end else begin
      if (!qc_on || win_end) begin
        win_cnt_q <= '0;
        bad_q     <= 1'b0;
      end else if (osc_bad && pwr_q != P_FCHK) begin
        win_cnt_q <= '0;
      end else begin
        win_cnt_q <= win_cnt_q + 13'h0001;
        bad_q     <= bad_q | osc_bad;
      end
      if (pwr_q != P_FCHK) begin
        nwin_q <= '0;
      end else if (win_end && !qc_ok) begin
        nwin_q <= nwin_q + 6'h01;
      end
    end
  end

  // Reset generator state machine.
  always_comb begin
    rs_d  = rs_q;
    vec_d = VEC_POR;
    case (rs_q)
      R_IDLE: begin
        if (rst_ev) begin
          rs_d = R_DRIVE;
        end
      end
      R_DRIVE: begin
        if (seq_cnt_q == PIN_LOW_CYC + SYNC_EXTRA - 8'h01) begin
          rs_d = R_WAIT;
        end
      end
      R_WAIT: begin
        if (seq_cnt_q == SAMPLE_CYC - 8'h01) begin
          rs_d = pin_low ? R_HOLD : R_IDLE;
        end
        if (cm_pend_q) begin
          vec_d = VEC_CLK;
        end else if (wd_pend_q) begin
          vec_d = VEC_WDOG;
        end
      end
      R_HOLD: begin
        if (!pin_low) begin
          rs_d = R_IDLE;
        end
      end
      default: rs_d = R_IDLE;
    endcase
  end

  // Reset generator registers; the async reset is power-on entry.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rs_q           <= R_IDLE;
      seq_cnt_q      <= '0;
      por_q          <= 1'b1;
      o_int_reset    <= 1'b1;
      o_rst_pin_oe_n <= 1'b1;
      o_vector       <= VEC_POR;
      o_vector_valid <= 1'b0;
    end else begin
      rs_q           <= rs_d;
      seq_cnt_q      <= (rs_d != rs_q) ? 8'h00 : seq_cnt_q + 8'h01;
      por_q          <= 1'b0;
      o_rst_pin_oe_n <= (rs_d != R_DRIVE);
      o_vector_valid <= seq_done;
      if (seq_done) begin
        o_vector    <= vec_d;
        o_int_reset <= 1'b0;
      end else if (rst_ev) begin
        o_int_reset <= 1'b1;
      end
    end
  end

  assign o_rst_pin_out = 1'b0;

  // Pending causes; a new event wins over the clear at completion.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cm_pend_q  <= 1'b0;
      wd_pend_q  <= 1'b0;
      ext_pend_q <= 1'b0;
    end else begin
      cm_pend_q  <= cm_rst_ev | (cm_pend_q & ~seq_done);
      wd_pend_q  <= i_wdog_timeout | (wd_pend_q & ~seq_done);
      if (pwr_q == P_FULL && pin_low) begin
        ext_pend_q <= 1'b1;
      end else if (pwr_q != P_FCHK) begin
        ext_pend_q <= 1'b0;
      end
    end
  end

  // Power state machine.
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      P_RUN: begin
        if (i_stop_req && !rst_ev && rs_q == R_IDLE) begin
          pwr_d = ctrl_q[CB_LSS] ? P_PSEUDO : P_FULL;
        end
      end
      P_PSEUDO: begin
        if (rst_ev || i_wakeup_irq) begin
          pwr_d = P_RUN;
        end else if (scm_set && ctrl_q[CB_SIE]) begin
          pwr_d = P_RUN;
        end
      end
      P_FULL: begin
        if (i_wakeup_irq || pin_low) begin
          pwr_d = P_FCHK;
        end
      end
      P_FCHK: begin
        if (qc_ok || fchk_fail) begin
          pwr_d = P_RUN;
        end
      end
      default: pwr_d = P_RUN;
    endcase
  end

  assign in_stop_d = (pwr_d != P_RUN);
  assign scm_d = (scm_set | cm_rst_ev | (fchk_fail & ctrl_q[CB_SFE]))
               | (scm_q & ~qc_ok);

  // Clock source and power enables.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      pwr_q            <= P_RUN;
      scm_q            <= 1'b0;
      o_selfclock_mode <= 1'b0;
      o_regulator_en   <= 1'b1;
      o_loop_osc_en    <= 1'b0;
      o_stopped        <= 1'b0;
    end else begin
      pwr_q            <= pwr_d;
      scm_q            <= scm_d;
      o_selfclock_mode <= scm_d;
      o_regulator_en   <= ~in_stop_d | scm_d;
      o_loop_osc_en    <= scm_d | (~in_stop_d & ctrl_q[CB_LCS] & (pwr_q == P_RUN));
      o_stopped        <= in_stop_d;
    end
  end

  // Control register; any reset event restores its defaults.
  // The loop clock select output is a twin flop, so it changes in the same cycle as the bit.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_q           <= CTRL_RST;
      o_loop_clock_sel <= CTRL_RST[CB_LCS];
    end else if (rst_ev) begin
      ctrl_q           <= CTRL_RST;
      o_loop_clock_sel <= CTRL_RST[CB_LCS];
    end else begin
      if (i_bus.wr && i_bus.addr == ADDR_CTRL) begin
        ctrl_q           <= i_bus.wdata[4:0];
        o_loop_clock_sel <= i_bus.wdata[CB_LCS];
      end
      if (pwr_q != P_RUN && pwr_d == P_RUN) begin
        ctrl_q[CB_LCS]   <= 1'b0;
        o_loop_clock_sel <= 1'b0;
      end
    end
  end

  // Sticky status, mask and interrupt; a set wins over a write-one clear.
  assign stat_set[SB_SCF]  = scm_d != scm_q;
  assign stat_set[SB_WAKE] = (pwr_q != P_RUN) & (pwr_d == P_RUN);
  assign stat_set[SB_CHK]  = qc_ok;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      stat_q <= '0;
      mask_q <= '0;
      o_irq  <= 1'b0;
    end else begin
      if (i_bus.wr && i_bus.addr == ADDR_STAT) begin
        stat_q <= (stat_q & ~i_bus.wdata[2:0]) | stat_set;
      end else begin
        stat_q <= stat_q | stat_set;
      end
      if (i_bus.wr && i_bus.addr == ADDR_MASK) begin
        mask_q <= i_bus.wdata[2:0];
      end
      o_irq <= |(stat_q & mask_q);
    end
  end

  // Read port; unmapped addresses read zero.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        ADDR_CTRL:  o_rdata <= {27'h000_0000, ctrl_q};
        ADDR_STAT:  o_rdata <= {29'h0000_0000, stat_q};
        ADDR_MASK:  o_rdata <= {29'h0000_0000, mask_q};
        ADDR_STATE: o_rdata <= {20'h0_0000, o_vector, pwr_q, rs_q, scm_q, o_int_reset};
        default:    o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_drive_start;
    $fell(o_rst_pin_oe_n);
  endsequence

  sequence s_stop_exit;
    (pwr_q != P_RUN) ##1 (pwr_q == P_RUN);
  endsequence

  drive_len_a: assert property (s_drive_start |-> ##A_DRV $rose(o_rst_pin_oe_n))
    else $error("Reset pin low time is wrong.");

  sample_wait_a: assert property ($rose(o_rst_pin_oe_n)
    |-> ##A_WAIT (rs_q == R_WAIT) ##1 (rs_q != R_WAIT))
    else $error("Pin sample point is wrong.");

  hold_low_a: assert property ((rs_q == R_HOLD) |-> o_int_reset)
    else $error("Internal reset dropped while pin held low.");

  int_release_a: assert property ($fell(o_int_reset)
    |-> o_vector_valid && ($past(rs_q) == R_WAIT || $past(rs_q) == R_HOLD))
    else $error("Internal reset released outside sequence end.");

  vec_pick_a: assert property (o_vector_valid && $past(rs_q) == R_WAIT && $past(cm_pend_q)
    |-> o_vector == VEC_CLK)
    else $error("Clock loss vector not chosen.");

  cm_reset_a: assert property ((pwr_q == P_PSEUDO) && loss_det && !ctrl_q[CB_SFE]
    && (rs_q == R_IDLE) |=> (rs_q == R_DRIVE) && (pwr_q == P_RUN))
    else $error("Clock loss reset not started.");

  scm_enter_a: assert property ((pwr_q == P_PSEUDO) && scm_set && !ctrl_q[CB_SIE]
    && !rst_ev && !i_wakeup_irq
    |=> (pwr_q == P_PSEUDO) && o_selfclock_mode && stat_q[SB_SCF] && o_regulator_en)
    else $error("Self-clock fallback in light sleep wrong.");

  full_quiet_a: assert property ((pwr_q == P_FULL) && !scm_q && osc_bad
    |=> !o_selfclock_mode && o_stopped)
    else $error("Clock loss seen in deep sleep.");

  wake_sel_a: assert property (s_stop_exit |-> !o_loop_clock_sel)
    else $error("Loop clock select kept after sleep.");
endmodule

// File: ssq_seq_tb_top.sv
// Self-checking bench for the stop/wake and reset sequencer.
// Assumes ssq_pkg and ssq_pin_model are compiled before this file.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t mismatch %h vs %h", $time, a, b); end end
module ssq_seq_tb_top;
  import ssq_pkg::*;
  logic        clk, rst, pin, hold_low, osc_fail, wdog, low_v, stop_req, wake;
  logic        pin_out, oe_n, int_rst, vvalid, selfclock_mode, reg_en, loop_en, lsel, stopped, irq;
  logic [31:0] rdata, d;
  ssq_bus_t    bus;
  ssq_vec_t    vec;
  int          num_errors, n_checks, seed, k;

  // Free-running 200 MHz clock.
  always #2.5 clk = ~clk;

  ssq_seq i_dut (.i_core_clk(clk), .i_reset(rst), .i_bus(bus), .o_rdata(rdata),
    .i_rst_pin(pin), .o_rst_pin_out(pin_out), .o_rst_pin_oe_n(oe_n),
    .i_osc_fail(osc_fail), .i_wdog_timeout(wdog), .i_low_volt(low_v),
    .i_stop_req(stop_req), .i_wakeup_irq(wake), .o_int_reset(int_rst), .o_vector(vec),
    .o_vector_valid(vvalid), .o_selfclock_mode(selfclock_mode), .o_regulator_en(reg_en),
    .o_loop_osc_en(loop_en), .o_loop_clock_sel(lsel), .o_stopped(stopped), .o_irq(irq));

  ssq_pin_model i_pin (.i_pin_out(pin_out), .i_pin_oe_n(oe_n), .i_hold_low(hold_low),
    .o_pin(pin));

  // Reference choice of vector from sampled pin and pending causes.
  function automatic ssq_vec_t exp_vec(input int lo, input int cm, input int wd);
    if (lo != 0 || (cm == 0 && wd == 0)) return VEC_POR;
    return (cm != 0) ? VEC_CLK : VEC_WDOG;
  endfunction

  // n clocks, then let the last edge's updates settle.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic stop;
    @(posedge clk);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    cyc(1);
    `CHK(stopped, 1'b1)
  endtask

  task automatic pulse_wake;
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
  endtask

  // Follows one reset sequence: pin drive length, wait, vector and release.
  task automatic run_seq(input ssq_vec_t ev, input int hold);
    int lo, wt;
    #1; // Step off the edge so a pin drive launched there is counted.
    lo = 0;
    wt = 0;
    while (oe_n !== 1'b0 && wt < 50) begin cyc(1); wt++; end
    while (oe_n === 1'b0 && lo < 300) begin `CHK(int_rst, 1'b1) lo++; cyc(1); end
    `CHK(lo inside {[131:134]}, 1'b1)
    wt = 0;
    while (vvalid !== 1'b1 && wt < 3000) begin `CHK(int_rst, 1'b1) wt++; cyc(1); end
    if (hold != 0) `CHK(wt >= 200, 1'b1)
    else `CHK(wt inside {[64:68]}, 1'b1)
    `CHK(vec, ev)
    `CHK(int_rst, 1'b0)
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected length of the run.
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    results();
  end

  // Main sequence of scenarios.
  initial begin
    seed = 64;
    clk = 1'b0;
    rst = 1'b1;
    {hold_low, osc_fail, wdog, low_v, stop_req, wake} = '0;
    bus = '0;
    num_errors = 0;
    n_checks = 0;
    #1 `CHK(int_rst, 1'b1)
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    run_seq(exp_vec(0, 0, 0), 0);
    rd(ADDR_CTRL);
    `CHK(d, {27'h0, CTRL_RST})
    wr(4'h2, $random(seed));
    rd(4'h2);
    `CHK(d, 32'h0000_0000)
    $display("test power-on done");
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      if (k == 0) wdog <= 1'b1;
      else low_v <= 1'b1;
      @(posedge clk);
      wdog <= 1'b0;
      low_v <= 1'b0;
      run_seq(exp_vec(0, 0, k == 0), 0);
    end
    @(posedge clk);
    hold_low <= 1'b1;
    fork
      run_seq(exp_vec(1, 0, 0), 1);
      begin repeat (400) @(posedge clk); hold_low <= 1'b0; end
    join
    $display("test reset sources done");
    wr(ADDR_CTRL, 32'h0000_0009);
    stop();
    @(posedge clk);
    osc_fail <= 1'b1;
    fork
      run_seq(exp_vec(0, 1, 0), 0);
      begin repeat (20) @(posedge clk); osc_fail <= 1'b0; end
    join
    k = 0;
    while (selfclock_mode !== 1'b0 && k < 6000) begin cyc(1); k++; end
    `CHK(selfclock_mode, 1'b0)
    $display("test clock-loss reset done");
    wr(ADDR_STAT, 32'h0000_0007);
    wr(ADDR_CTRL, 32'h0000_001B);
    stop();
    @(posedge clk);
    osc_fail <= 1'b1;
    cyc(10);
    `CHK(stopped, 1'b1)
    `CHK({selfclock_mode, reg_en, loop_en}, 3'b111)
    rd(ADDR_STAT);
    `CHK(d[SB_SCF], 1'b1)
    @(posedge clk);
    osc_fail <= 1'b0;
    cyc(4000);
    `CHK(selfclock_mode, 1'b1)
    cyc(200);
    `CHK({selfclock_mode, reg_en, loop_en, stopped}, 4'b0001)
    pulse_wake();
    cyc(2);
    `CHK(stopped, 1'b0)
    rd(ADDR_CTRL);
    `CHK(d[CB_LCS], 1'b0)
    `CHK(lsel, 1'b0)
    $display("test light sleep recovery done");
    wr(ADDR_STAT, 32'h0000_0007);
    wr(ADDR_MASK, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_000F);
    stop();
    @(posedge clk);
    osc_fail <= 1'b1;
    cyc(10);
    `CHK({stopped, selfclock_mode, irq}, 3'b011)
    wr(ADDR_MASK, 32'h0000_0000);
    cyc(2);
    `CHK(irq, 1'b0)
    wr(ADDR_MASK, 32'h0000_0001);
    cyc(2);
    `CHK(irq, 1'b1)
    wr(ADDR_STAT, 32'h0000_0001);
    cyc(2);
    `CHK(irq, 1'b0)
    @(posedge clk);
    osc_fail <= 1'b0;
    cyc(4200);
    `CHK(selfclock_mode, 1'b0)
    $display("test self-clock wake done");
    wr(ADDR_MASK, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0003);
    stop();
    @(posedge clk);
    osc_fail <= 1'b1;
    cyc(20);
    `CHK({stopped, oe_n}, 2'b11)
    @(posedge clk);
    osc_fail <= 1'b0;
    cyc(10);
    pulse_wake();
    cyc(4000);
    `CHK(stopped, 1'b1)
    cyc(300);
    `CHK(stopped, 1'b0)
    $display("test deep sleep done");
    @(posedge clk);
    rst <= 1'b1;
    cyc(1);
    `CHK({int_rst, oe_n}, 2'b11)
    @(posedge clk);
    rst <= 1'b0;
    run_seq(exp_vec(0, 0, 0), 0);
    $display("test second reset done");
    results();
  end
endmodule
